/* inc/spm_pkg.sv */
/*
  Constants for the shared pin ownership mux: pin count, owner codes,
  register offsets, field positions and reset values.
  Assumes a 32-bit classic Wishbone register bus and one 125 MHz clock.
*/
package spm_pkg;
  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int NPIN = 37;            // Shared pins
  localparam int AW = 4;               // Word address bits used
  // ==========================================================
  // Owner codes
  // ==========================================================
  typedef enum logic [1:0]
  {
    SPM_OWN_PORT = 2'b00,
    SPM_OWN_FIRST_ALTERNATE_FUNCTION = 2'b01,
    SPM_OWN_SECOND_ALTERNATE_FUNCTION = 2'b10
  } spm_owner_e;
  // ==========================================================
  // Register word offsets (byte address = 4 * index)
  // ==========================================================
  localparam logic [AW-1:0] REG_PORT_DATA_LO = 4'h0;
  localparam logic [AW-1:0] REG_PORT_DATA_HI = 4'h1;
  localparam logic [AW-1:0] REG_PORT_DIR_LO = 4'h2;
  localparam logic [AW-1:0] REG_PORT_DIR_HI = 4'h3;
  localparam logic [AW-1:0] REG_DRIVE_LO = 4'h4;
  localparam logic [AW-1:0] REG_DRIVE_HI = 4'h5;
  localparam logic [AW-1:0] REG_SLEW_LO = 4'h6;
  localparam logic [AW-1:0] REG_SLEW_HI = 4'h7;
  localparam logic [AW-1:0] REG_PULL_LO = 4'h8;
  localparam logic [AW-1:0] REG_PULL_HI = 4'h9;
  localparam logic [AW-1:0] REG_PAD_IN_LO = 4'hA;
  localparam logic [AW-1:0] REG_PAD_IN_HI = 4'hB;
  localparam logic [AW-1:0] REG_MISC = 4'hC;
  // ==========================================================
  // Fields of the misc register
  // ==========================================================
  localparam int MISC_IRQ_EN_BIT = 0;  // Interrupt function enable
  localparam int MISC_USB_PU_BIT = 1;  // Plus line pullup enable
  localparam int MISC_IRQ_LVL_BIT = 2; // Read only pin level
  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [NPIN-1:0] RST_PINS = 37'h00_0000_0000;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_USB_PU = 1'b0;
endpackage : spm_pkg

/* core/spm_mux.sv */
/*
  Shared pin ownership mux with classic Wishbone register slave.
  Assumes pads resolve their own wires from the enables given here and
  that peripheral requests come from logic on clk_i.
*/
`timescale 1ns/1ps
module spm_mux
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Alternate function requests
  input wire logic [spm_pkg::NPIN-1:0] first_alternate_function_en_i,
  input wire logic [spm_pkg::NPIN-1:0] first_alternate_function_out_i,
  input wire logic [spm_pkg::NPIN-1:0] first_alternate_function_oe_i,
  input wire logic [spm_pkg::NPIN-1:0] second_alternate_function_en_i,
  input wire logic [spm_pkg::NPIN-1:0] second_alternate_function_out_i,
  input wire logic [spm_pkg::NPIN-1:0] second_alternate_function_oe_i,
  // Pads
  input wire logic [spm_pkg::NPIN-1:0] pad_in_i,
  output logic [spm_pkg::NPIN-1:0] pad_out_o,
  output logic [spm_pkg::NPIN-1:0] pad_oe_o,
  output logic [spm_pkg::NPIN-1:0] pad_drive_high_o,
  output logic [spm_pkg::NPIN-1:0] pad_slew_limit_o,
  output logic [spm_pkg::NPIN-1:0] pad_pullup_o,
  output logic [spm_pkg::NPIN-1:0] pin_in_o,
  // Interrupt pin
  input wire logic int_pin_i,
  output logic int_pin_level_o,
  output logic branch_if_int_pin_high_o,
  output logic branch_if_int_pin_low_o,
  output logic timer_external_clock_in_o,
  output logic int_function_en_o,
  // USB plus line
  output logic plus_line_pullup_o
);
  // ==========================================================
  // Declarations
  // ==========================================================
  localparam int NP = spm_pkg::NPIN;
  logic [NP-1:0] port_data_r;          // Port output latch
  logic [NP-1:0] port_dir_r;           // 1 = port output
  logic [NP-1:0] drive_r;              // 1 = high drive
  logic [NP-1:0] slew_r;               // 1 = slew limit on
  logic [NP-1:0] pull_r;               // 1 = pullup wanted
  logic irq_en_r;                      // Interrupt function on
  logic usb_pu_r;                      // Plus line pullup on
  logic [NP-1:0] pad_s1_r;             // Pad sync stage 1
  logic [NP-1:0] pad_s2_r;             // Pad sync stage 2
  logic [NP-1:0] pad_s3_r;             // Pad sync stage 3
  logic [NP-1:0] pad_q_r;              // Debounced pad value
  logic int_s1_r;                      // Interrupt pin stage 1
  logic int_s2_r;                      // Interrupt pin stage 2
  logic int_s3_r;                      // Interrupt pin stage 3
  logic int_q_r;                       // Settled interrupt level
  logic [NP-1:0] own_out;              // Owner output value
  logic [NP-1:0] own_oe;               // Owner output enable
  logic [spm_pkg::AW-1:0] widx;        // Word index
  logic req;                           // New bus request
  logic [31:0] rd_nxt;                 // Read mux
  // ==========================================================
  // Ownership by fixed priority
  // ==========================================================
  // Second alternate over first over port
  // A disabled function has no say over the pin
  always_comb
  begin
    for (int i = 0; i < NP; i++)
    begin
      if (second_alternate_function_en_i[i])
      begin
        own_out[i] = second_alternate_function_out_i[i];
        own_oe[i] = second_alternate_function_oe_i[i];
      end
      else if (first_alternate_function_en_i[i])
      begin
        own_out[i] = first_alternate_function_out_i[i];
        own_oe[i] = first_alternate_function_oe_i[i];
      end
      else
      begin
        own_out[i] = port_data_r[i];
        own_oe[i] = port_dir_r[i];
      end
    end
  end
  // ==========================================================
  // Pad drive, registered
  // ==========================================================
  // Output value, enable and pad options
  // Registered so a change of owner never glitches a pad
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_out_o <= spm_pkg::RST_PINS;
      pad_oe_o <= spm_pkg::RST_PINS;
      pad_drive_high_o <= spm_pkg::RST_PINS;
      pad_slew_limit_o <= spm_pkg::RST_PINS;
      pad_pullup_o <= spm_pkg::RST_PINS;
      plus_line_pullup_o <= spm_pkg::RST_USB_PU;
    end
    else
    begin
      pad_out_o <= own_out;
      pad_oe_o <= own_oe;
      // Options only matter while output
      pad_drive_high_o <= drive_r & own_oe;
      pad_slew_limit_o <= slew_r & own_oe;
      // Pullup only while input
      pad_pullup_o <= pull_r & ~own_oe;
      plus_line_pullup_o <= usb_pu_r;
    end
  end
  // ==========================================================
  // Input synchronisers
  // ==========================================================
  // Three stages; change taken when stages 2 and 3 agree
  // Stage 1 may go metastable; only stage 2 reads it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_s1_r <= spm_pkg::RST_PINS;
      pad_s2_r <= spm_pkg::RST_PINS;
      pad_s3_r <= spm_pkg::RST_PINS;
      pad_q_r <= spm_pkg::RST_PINS;
      int_s1_r <= 1'b0;
      int_s2_r <= 1'b0;
      int_s3_r <= 1'b0;
      int_q_r <= 1'b0;
    end
    else
    begin
      pad_s1_r <= pad_in_i;
      pad_s2_r <= pad_s1_r;
      pad_s3_r <= pad_s2_r;
      for (int i = 0; i < NP; i++)
      begin
        if (pad_s2_r[i] == pad_s3_r[i])
        begin
          pad_q_r[i] <= pad_s3_r[i];
        end
      end
      int_s1_r <= int_pin_i;
      int_s2_r <= int_s1_r;
      int_s3_r <= int_s2_r;
      if (int_s2_r == int_s3_r)
      begin
        int_q_r <= int_s3_r;
      end
    end
  end
  // ==========================================================
  // Input delivery
  // ==========================================================
  // Pad level to every sharer; interrupt pin routing
  // Branch levels are complementary copies of one settled level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_in_o <= spm_pkg::RST_PINS;
      int_pin_level_o <= 1'b0;
      branch_if_int_pin_high_o <= 1'b0;
      branch_if_int_pin_low_o <= 1'b0;
      timer_external_clock_in_o <= 1'b0;
      int_function_en_o <= spm_pkg::RST_IRQ_EN;
    end
    else
    begin
      pin_in_o <= pad_q_r;
      int_pin_level_o <= int_q_r;
      branch_if_int_pin_high_o <= int_q_r;
      branch_if_int_pin_low_o <= ~int_q_r;
      // Timer clock only with interrupt function off
      timer_external_clock_in_o <= int_q_r & ~irq_en_r;
      int_function_en_o <= irq_en_r;
    end
  end
  // ==========================================================
  // Wishbone slave
  // ==========================================================
  // Word index from byte address; byte offset bits ignored
  assign widx = adr_i[5:2];
  assign req = cyc_i & stb_i & ~ack_o;
  // Ack one cycle after request, then drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= req;
    end
  end
  // Register writes, byte lanes honoured
  // Writes land on the request edge, the same edge that raises ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_data_r <= spm_pkg::RST_PINS;
      port_dir_r <= spm_pkg::RST_PINS;
      drive_r <= spm_pkg::RST_PINS;
      slew_r <= spm_pkg::RST_PINS;
      pull_r <= spm_pkg::RST_PINS;
      irq_en_r <= spm_pkg::RST_IRQ_EN;
      usb_pu_r <= spm_pkg::RST_USB_PU;
    end
    else if (req && we_i)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (sel_i[b])
        begin
          for (int k = 0; k < 8; k++)
          begin
            if (b * 8 + k < 32)
            begin
              case (widx)
                spm_pkg::REG_PORT_DATA_LO: port_data_r[b*8+k] <= dat_i[b*8+k];
                spm_pkg::REG_PORT_DIR_LO: port_dir_r[b*8+k] <= dat_i[b*8+k];
                spm_pkg::REG_DRIVE_LO: drive_r[b*8+k] <= dat_i[b*8+k];
                spm_pkg::REG_SLEW_LO: slew_r[b*8+k] <= dat_i[b*8+k];
                spm_pkg::REG_PULL_LO: pull_r[b*8+k] <= dat_i[b*8+k];
                default: ;
              endcase
            end
          end
        end
      end
      // High words hold pins 32..36 in byte lane 0
      if (sel_i[0])
      begin
        case (widx)
          spm_pkg::REG_PORT_DATA_HI: port_data_r[NP-1:32] <= dat_i[NP-33:0];
          spm_pkg::REG_PORT_DIR_HI: port_dir_r[NP-1:32] <= dat_i[NP-33:0];
          spm_pkg::REG_DRIVE_HI: drive_r[NP-1:32] <= dat_i[NP-33:0];
          spm_pkg::REG_SLEW_HI: slew_r[NP-1:32] <= dat_i[NP-33:0];
          spm_pkg::REG_PULL_HI: pull_r[NP-1:32] <= dat_i[NP-33:0];
          spm_pkg::REG_MISC:
          begin
            irq_en_r <= dat_i[spm_pkg::MISC_IRQ_EN_BIT];
            usb_pu_r <= dat_i[spm_pkg::MISC_USB_PU_BIT];
          end
          default: ;
        endcase
      end
    end
  end
  // Read mux; unmapped reads zero
  // Pad input words show the settled levels, not raw pins
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (widx)
      spm_pkg::REG_PORT_DATA_LO: rd_nxt = port_data_r[31:0];
      spm_pkg::REG_PORT_DATA_HI: rd_nxt[NP-33:0] = port_data_r[NP-1:32];
      spm_pkg::REG_PORT_DIR_LO: rd_nxt = port_dir_r[31:0];
      spm_pkg::REG_PORT_DIR_HI: rd_nxt[NP-33:0] = port_dir_r[NP-1:32];
      spm_pkg::REG_DRIVE_LO: rd_nxt = drive_r[31:0];
      spm_pkg::REG_DRIVE_HI: rd_nxt[NP-33:0] = drive_r[NP-1:32];
      spm_pkg::REG_SLEW_LO: rd_nxt = slew_r[31:0];
      spm_pkg::REG_SLEW_HI: rd_nxt[NP-33:0] = slew_r[NP-1:32];
      spm_pkg::REG_PULL_LO: rd_nxt = pull_r[31:0];
      spm_pkg::REG_PULL_HI: rd_nxt[NP-33:0] = pull_r[NP-1:32];
      spm_pkg::REG_PAD_IN_LO: rd_nxt = pad_q_r[31:0];
      spm_pkg::REG_PAD_IN_HI: rd_nxt[NP-33:0] = pad_q_r[NP-1:32];
      spm_pkg::REG_MISC:
      begin
        rd_nxt[spm_pkg::MISC_IRQ_EN_BIT] = irq_en_r;
        rd_nxt[spm_pkg::MISC_USB_PU_BIT] = usb_pu_r;
        rd_nxt[spm_pkg::MISC_IRQ_LVL_BIT] = int_q_r;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end
  // Read data registered with ack
  // Held until the next request so a slow master still sees it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (req)
    begin
      dat_o <= rd_nxt;
    end
  end
endmodule : spm_mux

/* verification/spm_periph.sv */
/*
  Peripheral side model: drives both alternate function request sets.
  Assumes the bench picks a mode by non-blocking assignment after an edge.
*/
`timescale 1ns/1ps
module spm_periph
#(
  parameter logic [36:0] A1OE = '0,
  parameter logic [36:0] A1OUT = '0,
  parameter logic [36:0] A2EN = '0,
  parameter logic [36:0] A2OE = '0,
  parameter logic [36:0] A2OUT = '0
)
(
  input wire logic [1:0] mode_i,
  output logic [spm_pkg::NPIN-1:0] f_en_o,
  output logic [spm_pkg::NPIN-1:0] f_out_o,
  output logic [spm_pkg::NPIN-1:0] f_oe_o,
  output logic [spm_pkg::NPIN-1:0] s_en_o,
  output logic [spm_pkg::NPIN-1:0] s_out_o,
  output logic [spm_pkg::NPIN-1:0] s_oe_o
);
  // ==========================================================
  // Mode 0 idle, 1 first alternate only, 2 both alternates
  // ==========================================================
  assign f_en_o = (mode_i != 2'd0) ? '1 : '0;
  assign f_out_o = A1OUT;
  assign f_oe_o = A1OE;
  assign s_en_o = (mode_i == 2'd2) ? A2EN : '0;
  assign s_out_o = A2OUT;
  assign s_oe_o = A2OE;
endmodule : spm_periph

/* verification/spm_mux_properties.sv */
/*
  Port checker for the pin mux.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module spm_mux_props
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [36:0] second_alternate_function_en_i,
  input wire logic [36:0] second_alternate_function_oe_i,
  input wire logic [36:0] second_alternate_function_out_i,
  input wire logic [36:0] pad_out_o,
  input wire logic [36:0] pad_oe_o,
  input wire logic [36:0] pad_drive_high_o,
  input wire logic [36:0] pad_slew_limit_o,
  input wire logic [36:0] pad_pullup_o,
  input wire logic int_pin_level_o,
  input wire logic branch_if_int_pin_high_o,
  input wire logic branch_if_int_pin_low_o,
  input wire logic timer_external_clock_in_o,
  input wire logic int_function_en_o
);
  // ==========================================================
  // Bus, ownership, pad option, interrupt pin routing and reset checks
  // ==========================================================
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  chk_second_alternate_function_oe: assert property (1'b1 |=>
    ((pad_oe_o ^ $past(second_alternate_function_oe_i))
    & $past(second_alternate_function_en_i)) == '0)
    else $error("oe owner");
  chk_second_alternate_function_val: assert property (1'b1 |=>
    ((pad_out_o ^ $past(second_alternate_function_out_i))
    & $past(second_alternate_function_en_i)) == '0)
    else $error("out owner");
  chk_drive_out: assert property ((pad_drive_high_o & ~pad_oe_o) == '0)
    else $error("drive on input");
  chk_slew_out: assert property ((pad_slew_limit_o & ~pad_oe_o) == '0)
    else $error("slew on input");
  chk_pull_input: assert property ((pad_pullup_o & pad_oe_o) == '0)
    else $error("pullup on output");
  chk_branch_pair: assert property (!$past(rst_i) |->
    branch_if_int_pin_high_o == int_pin_level_o && branch_if_int_pin_low_o != int_pin_level_o)
    else $error("branch");
  chk_timer_route: assert property (timer_external_clock_in_o ==
    (int_pin_level_o & ~int_function_en_o))
    else $error("timer clock");
  chk_reset_idle: assert property ($fell(rst_i) |->
    pad_oe_o == '0 && pad_pullup_o == '0)
    else $error("reset pads");
  cov_ack: cover property (ack_o);
  cov_second_alternate_function: cover property (second_alternate_function_en_i != '0);
  cov_timer: cover property (timer_external_clock_in_o);
endmodule : spm_mux_props
bind spm_mux spm_mux_props chk_u (.*);

/* verification/spm_mux_tb.sv */
/*
  Self-checking bench for the pin mux.
  Assumes the peripheral model and the checker bound to the mux.
*/
`timescale 1ns/1ps
module spm_mux_tb;
  localparam logic [36:0] A1OE = 37'h1F_0F0F_0F0F, A1OUT = 37'h15_5555_5555;
  localparam logic [36:0] A2EN = 37'h00_FFFF_0000, A2OE = 37'h00_FF00_0000;
  localparam logic [36:0] A2OUT = 37'h00_F0F0_0000, PIN = 37'h12_3456_789A;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, int_pin_i = 0;
  logic [5:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic ack_o, int_pin_level_o, branch_if_int_pin_high_o, branch_if_int_pin_low_o;
  logic timer_external_clock_in_o, int_function_en_o, plus_line_pullup_o;
  logic [36:0] pad_in_i = '0, pad_out_o, pad_oe_o, pad_drive_high_o, pad_slew_limit_o;
  logic [36:0] pad_pullup_o, pin_in_o, first_alternate_function_en_i, eoe, s;
  logic [36:0] first_alternate_function_out_i, first_alternate_function_oe_i;
  logic [36:0] second_alternate_function_en_i, second_alternate_function_out_i;
  logic [36:0] second_alternate_function_oe_i;
  logic [1:0] mode = '0;
  int n_fail = 0, checked = 0;
  always #4 clk_i = ~clk_i;
  spm_periph #(.A1OE(A1OE), .A1OUT(A1OUT), .A2EN(A2EN), .A2OE(A2OE), .A2OUT(A2OUT)) peer_u
  (.mode_i(mode), .f_en_o(first_alternate_function_en_i),
   .f_out_o(first_alternate_function_out_i), .f_oe_o(first_alternate_function_oe_i),
   .s_en_o(second_alternate_function_en_i), .s_out_o(second_alternate_function_out_i),
   .s_oe_o(second_alternate_function_oe_i));
  spm_mux dut_u (.*);
  // ==========================================================
  // Compare, bus cycle and verdict
  // ==========================================================
  task chk(input logic [36:0] g, input logic [36:0] e);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    sel_i <= 4'hF;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  task close_out;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(pad_oe_o, '0);
    chk(pad_pullup_o, '0);
    for (int i = 0; i < 15; i++)
    begin
      wb(1'b0, 4'(i), '0);
      chk(37'(rd), '0);
    end
    chk(37'($bits(pad_oe_o)), 37'd37);
    wb(1'b1, spm_pkg::REG_PORT_DIR_LO, 32'hFFFF_FFFF);
    wb(1'b1, spm_pkg::REG_PORT_DATA_LO, 32'h5555_AAAA);
    wb(1'b1, spm_pkg::REG_DRIVE_LO, 32'h00FF_FF00);
    wb(1'b1, spm_pkg::REG_SLEW_LO, 32'h0000_FFFF);
    wb(1'b1, spm_pkg::REG_PULL_LO, 32'hFFFF_FFFF);
    wb(1'b1, spm_pkg::REG_PULL_HI, 32'h0000_001F);
    repeat (3) @(posedge clk_i);
    chk(pad_oe_o, 37'h00_FFFF_FFFF);
    chk(pad_out_o, 37'h00_5555_AAAA);
    chk(pad_drive_high_o, 37'h00_00FF_FF00);
    chk(pad_slew_limit_o, 37'h00_0000_FFFF);
    chk(pad_pullup_o, 37'h1F_0000_0000);
    for (int m = 1; m < 3; m++)
    begin
      mode <= 2'(m);
      repeat (3) @(posedge clk_i);
      s = (m == 2) ? A2EN : '0;
      eoe = (s & A2OE) | (~s & A1OE);
      chk(pad_oe_o, eoe);
      chk(pad_out_o, (s & A2OUT) | (~s & A1OUT));
      chk(pad_pullup_o, ~eoe);
    end
    mode <= 2'd0;
    pad_in_i <= PIN;
    repeat (6) @(posedge clk_i);
    chk(pad_oe_o, 37'h00_FFFF_FFFF);
    chk(pin_in_o, PIN);
    wb(1'b0, spm_pkg::REG_PAD_IN_HI, '0);
    chk(37'(rd), 37'h12);
    int_pin_i <= 1'b1;
    wb(1'b1, spm_pkg::REG_MISC, 32'h0000_0002);
    repeat (6) @(posedge clk_i);
    chk(37'({timer_external_clock_in_o, branch_if_int_pin_high_o, branch_if_int_pin_low_o,
      int_function_en_o, plus_line_pullup_o, int_pin_level_o}), 37'b110011);
    wb(1'b1, spm_pkg::REG_MISC, 32'h0000_0001);
    repeat (6) @(posedge clk_i);
    chk(37'({timer_external_clock_in_o, int_function_en_o, plus_line_pullup_o}), 37'b010);
    wb(1'b0, spm_pkg::REG_MISC, '0);
    chk(37'(rd), 37'h5);
    // Mid-run reset returns pads and registers to idle
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(pad_oe_o, '0);
    chk(pad_pullup_o, '0);
    chk(37'(plus_line_pullup_o), '0);
    wb(1'b0, spm_pkg::REG_PORT_DIR_LO, '0);
    chk(37'(rd), '0);
    close_out();
  end
endmodule : spm_mux_tb
